// *** sar_adc_sequencer.v ***
// Sequencer logic for the 8-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_consts.vh"

module sar_adc_sequencer (
   input  wire       sys_clk,
   input  wire       reset_n,
   input  wire [7:0] regAddr,
   input  wire [7:0] regWrData,
   input  wire       regWrite,
   input  wire       regRead,
   output reg  [7:0] regRdData,
   input  wire       cpuWait,
   input  wire       cpuHalt,
   input  wire       compareHigh,
   output reg  [3:0] channelSelect,
   output reg        sampleConnect,
   output reg  [7:0] dacCode,
   output wire       converterPowered
);

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_LOAD = 2'b01;
   localparam [1:0] ST_CONV = 2'b10;

   reg       haltSync1Q;
   reg       haltSync2Q;
   reg       converterOnQ;
   reg       doneFlagQ;
   reg [7:0] resultQ;
   reg [1:0] stateQ;
   reg [3:0] periodQ;
   reg [7:0] sarQ;
   reg       adcTickQ;

   wire ctrlWrite  = regWrite && (regAddr == `ADC_CTRL_ADDR);
   wire resultRead = regRead && (regAddr == `ADC_RESULT_ADDR);
   // Effective enable; halt powers the converter down, wait is ignored
   wire runEnable  = converterOnQ && !haltSync2Q;
   wire finishNow  = (stateQ == ST_CONV) && adcTickQ
                     && (periodQ == `ADC_CONV_PERIODS - 4'h1);

   assign converterPowered = runEnable;

   // Trial bit for the step that starts at a given period
   function [7:0] trialBit;
      input [3:0] period;
      begin
         trialBit = 8'h80 >> (period - `ADC_LOAD_PERIODS);
      end
   endfunction

   // Halt pin synchroniser; comparator follows our own registered code
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         haltSync1Q <= 1'b0;
         haltSync2Q <= 1'b0;
      end else begin
         haltSync1Q <= cpuHalt;
         haltSync2Q <= haltSync1Q;
      end
   end

   // Converter clock enable at half the CPU rate
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         adcTickQ <= 1'b0;
      end else if (!runEnable || ctrlWrite) begin
         adcTickQ <= 1'b0;
      end else begin
         adcTickQ <= !adcTickQ;
      end
   end

   // Control register
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         converterOnQ  <= 1'b0;
         channelSelect <= 4'h0;
      end else if (ctrlWrite) begin
         converterOnQ  <= regWrData[`ADC_ON_BIT];
         channelSelect <= regWrData[`ADC_CH_HI:`ADC_CH_LO];
      end
   end

   // Sequencer: load phase, then one comparison per converter clock
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stateQ  <= ST_IDLE;
         periodQ <= 4'h0;
         sarQ    <= 8'h00;
      end else if (ctrlWrite) begin
         stateQ  <= regWrData[`ADC_ON_BIT] ? ST_LOAD : ST_IDLE;
         periodQ <= 4'h0;
         sarQ    <= 8'h00;
      end else if (!runEnable) begin
         stateQ  <= ST_IDLE;
         periodQ <= 4'h0;
         sarQ    <= 8'h00;
      end else if (adcTickQ) begin
         case (stateQ)
            ST_IDLE: begin
               stateQ  <= ST_LOAD;
               periodQ <= 4'h0;
            end
            ST_LOAD: begin
               periodQ <= periodQ + 4'h1;
               if (periodQ == `ADC_LOAD_PERIODS - 4'h1) begin
                  stateQ <= ST_CONV;
                  sarQ   <= 8'h00;
               end
            end
            ST_CONV: begin
               // Keep the trial bit only when input is at or above code
               // Code moved one cycle earlier, so comparator has settled
               if (compareHigh) begin
                  sarQ <= sarQ | trialBit(periodQ);
               end
               if (periodQ == `ADC_CONV_PERIODS - 4'h1) begin
                  stateQ  <= ST_LOAD;
                  periodQ <= 4'h0;
               end else begin
                  periodQ <= periodQ + 4'h1;
               end
            end
            default: begin
               stateQ  <= ST_IDLE;
               periodQ <= 4'h0;
            end
         endcase
      end
   end

   // Analog side drives
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sampleConnect <= 1'b0;
         dacCode       <= 8'h00;
      end else begin
         sampleConnect <= (stateQ == ST_LOAD) && runEnable;
         dacCode       <= (stateQ == ST_CONV && runEnable) ? (sarQ | trialBit(periodQ)) : 8'h00;
      end
   end

   // Result and done flag; set wins over a result-read clear, a control write blocks set and clears
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         resultQ   <= `ADC_RESULT_RESET;
         doneFlagQ <= 1'b0;
      end else if (finishNow && !ctrlWrite && runEnable) begin
         resultQ   <= compareHigh ? (sarQ | 8'h01) : sarQ;
         doneFlagQ <= 1'b1;
      end else if (ctrlWrite || resultRead) begin
         doneFlagQ <= 1'b0;
      end
   end

   // Register read port, one cycle latency
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         if (regAddr == `ADC_RESULT_ADDR) begin
            regRdData <= resultQ;
         end else if (regAddr == `ADC_CTRL_ADDR) begin
            regRdData <= {doneFlagQ, 1'b0, converterOnQ, 1'b0, channelSelect};
         end else begin
            regRdData <= 8'h00;
         end
      end else begin
         regRdData <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// *** sar_adc_consts.vh ***
// Constants for the SAR converter sequencer
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH
`define ADC_ADDR_W        8
`define ADC_RESULT_ADDR   8'h70
`define ADC_CTRL_ADDR     8'h71
`define ADC_RESULT_RESET  8'h00
`define ADC_CTRL_RESET    8'h00
`define ADC_DONE_BIT      7
`define ADC_ON_BIT        5
`define ADC_CH_HI         3
`define ADC_CH_LO         0
`define ADC_CONV_PERIODS  4'hC
`define ADC_LOAD_PERIODS  4'h4
`define ADC_SAR_STEPS     4'h8
`endif

// *** sar_adc_analog_model.sv ***
// Comparator and sample capacitor model
`timescale 1ns/1ps
`default_nettype none
module sar_adc_analog_model (
   input  wire logic [3:0] channelSelect,
   input  wire logic       sampleConnect,
   input  wire logic [7:0] dacCode,
   output logic            compareHigh
);
   logic [7:0] held = 8'h00;
   // Input n sits at n*11h; capacitor keeps the charge once cut off
   always @(negedge sampleConnect) held <= {channelSelect, channelSelect};
   assign compareHigh = held >= dacCode;
endmodule
`default_nettype wire

// *** sar_adc_sequencer_checker.sv ***
// Port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_checker (
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrite,
   input wire logic       cpuHalt,
   input wire logic [3:0] channelSelect,
   input wire logic       sampleConnect,
   input wire logic [7:0] dacCode,
   input wire logic       converterPowered
);
   wire ctrlWr = regWrite && regAddr == 8'h71;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_on_start: assert property (!cpuHalt [*3] ##0 (ctrlWr && regWrData[5]) |=>
      converterPowered ##[0:1] sampleConnect) else $error("start");
   a_chan_set: assert property (ctrlWr |=> channelSelect == $past(regWrData[3:0]))
      else $error("channel");
   a_halt_stop: assert property (cpuHalt [*3] |=> !converterPowered) else $error("halt");
   a_off_write: assert property (ctrlWr && !regWrData[5] |=> !converterPowered)
      else $error("off");
   a_off_quiet: assert property (!converterPowered [*2] |->
      !sampleConnect && dacCode == 8'h00) else $error("quiet");
   a_phase_excl: assert property (sampleConnect |-> dacCode == 8'h00) else $error("phase");
   a_load_len: assert property ($rose(sampleConnect) |->
      (sampleConnect || !converterPowered) [*8]) else $error("load");
   a_dac_start: assert property ($fell(sampleConnect) && converterPowered |->
      ##[0:1] dacCode == 8'h80) else $error("trial");
   c_conv: cover property ($fell(sampleConnect) && converterPowered);
   c_halt: cover property (cpuHalt [*3]);
   c_off: cover property (ctrlWr && !regWrData[5]);
endmodule
bind sar_adc_sequencer sar_adc_sequencer_checker chk_u (.*);
`default_nettype wire

// *** tb_sar_adc_sequencer.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_sequencer;
   logic       sys_clk = 0, reset_n = 0, regWrite = 0, regRead = 0, cpuWait = 0, cpuHalt = 0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, v;
   wire  [7:0] regRdData, dacCode;
   wire  [3:0] channelSelect;
   wire        compareHigh, sampleConnect, converterPowered;
   int         err_count = 0, comparisons = 0, i;
   sar_adc_sequencer dut_u (.*);
   sar_adc_analog_model model_u (.*);
   initial forever #50 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("mismatch reg %h expected %h seen %h", regAddr, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, d);
      @(posedge sys_clk);
      {regWrite, regRead, regAddr, regWrData} <= {w, !w, a, d};
      @(posedge sys_clk);
      {regWrite, regRead} <= 2'b00;
      #1 v = regRdData;
   endtask
   task automatic rc(input logic [7:0] a, e);
      bus(0, a, 8'h00);
      chk(e, v);
   endtask
   task automatic wait_done(input logic [7:0] c);
      v = 8'h00;
      for (i = 0; i < 30 && !v[7]; i++) bus(0, 8'h71, 8'h00);
      chk({1'b1, c[6:0]}, v);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic test_reset;
      rc(8'h70, 8'h00);
      rc(8'h71, 8'h00);
      bus(1, 8'h70, 8'hFF);
      rc(8'h70, 8'h00);
      $display("test_reset done");
   endtask
   task automatic test_channels;
      @(posedge sys_clk) cpuWait <= 1'b1;
      for (int k = 0; k < 16; k += 5) begin
         bus(1, 8'h71, {4'h2, 4'(k)});
         wait_done({4'h2, 4'(k)});
         chk(8'h01, {7'h00, i inside {[12:13]}});
         rc(8'h70, {4'(k), 4'(k)});
         rc(8'h71, {4'h2, 4'(k)});
         wait_done({4'h2, 4'(k)});
      end
      $display("test_channels done");
   endtask
   task automatic test_abort_halt;
      bus(1, 8'h71, 8'h25);
      repeat (20) @(posedge sys_clk);
      bus(1, 8'h71, 8'h25);
      repeat (12) @(posedge sys_clk);
      rc(8'h71, 8'h25);
      wait_done(8'h25);
      bus(1, 8'h71, 8'h2F);
      repeat (10) @(posedge sys_clk);
      bus(1, 8'h71, 8'h0F);
      repeat (40) @(posedge sys_clk);
      rc(8'h71, 8'h0F);
      rc(8'h70, 8'h55);
      bus(1, 8'h71, 8'h2F);
      @(posedge sys_clk) cpuHalt <= 1'b1;
      repeat (40) @(posedge sys_clk);
      rc(8'h71, 8'h2F);
      @(posedge sys_clk) cpuHalt <= 1'b0;
      wait_done(8'h2F);
      rc(8'h70, 8'hFF);
      $display("test_abort_halt done");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      test_reset;
      test_channels;
      test_abort_halt;
      final_report;
   end
   initial begin
      #400000;
      err_count++;
      final_report;
   end
endmodule
`default_nettype wire
